// file: rtl/gti_pkg.sv
// Shared constants and types of the gauge I2C target interface.
package gti_pkg;
   // ************************************************************
   // Bus identity and command map limits
   // ************************************************************
   localparam logic [6:0] TGT_ADDR = 7'h55;
   localparam logic [7:0] MAX_CMD  = 8'h6B;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_HZ      = 10_000_000;
   localparam int unsigned TIMEOUT_MS  = 2000;
   localparam int unsigned WAKE_US     = 4000;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned WAKE_CYC    = WAKE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned RELEASE_CHK = 4;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [7:0] {
      GTI_IDLE  = 8'h01,
      GTI_ADDR  = 8'h02,
      GTI_ACKA  = 8'h04,
      GTI_CMD   = 8'h08,
      GTI_ACKC  = 8'h10,
      GTI_WDATA = 8'h20,
      GTI_ACKW  = 8'h40,
      GTI_RDATA = 8'h80
   } gti_state_t;
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gti_cmd_t;
endpackage

// file: rtl/gti_target.sv
// I2C target engine of the gauge with pointer, timeout and clock stretching.
`timescale 1ns/1ps
// Functional notes
// - Answer only the fixed 7-bit address 1010101.
// - Support read, incremental read, quick read, single and incremental write.
// - Quick read returns the byte at the current pointer.
// - Pointer advances by one on every acknowledged data byte.
// - Multi-byte writes land at consecutive locations.
// - Data written to a read-only location is not acknowledged.
// - Command byte above 0x6B is not acknowledged.
// - Bus low for 2 seconds releases both SDA and SCL.
// - Lines still held low after that release enter sleep.
// - When asleep, stretch the clock at start of all traffic, up to 4 ms.
// - Otherwise stretch only within packets addressed to this device.
// - Resistance table updates may stretch about 24 ms or 144 ms.
// - Flash block writes may stretch about 72 ms or 116 ms.
module gti_target #(
   parameter int unsigned TIMEOUT_CYC = gti_pkg::TIMEOUT_CYC,
   parameter int unsigned WAKE_CYC    = gti_pkg::WAKE_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   input  wire logic        asleep_i,
   input  wire logic        busy_i,
   input  wire logic [7:0]  cmd_rdata,
   input  wire logic        cmd_ro,
   output logic             scl_o,
   output logic             scl_oe,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             sleep_o,
   output gti_pkg::gti_cmd_t cmd_o
);
   localparam int TW = $clog2(TIMEOUT_CYC + gti_pkg::RELEASE_CHK + 1);
   localparam int WW = $clog2(WAKE_CYC + 1);
   localparam logic [TW-1:0] TO_END  = TW'(TIMEOUT_CYC);
   localparam logic [TW-1:0] TO_SLP  = TW'(TIMEOUT_CYC + gti_pkg::RELEASE_CHK);
   localparam logic [WW-1:0] WK_END  = WW'(WAKE_CYC);

   if (TIMEOUT_CYC < 16 || WAKE_CYC < 2) begin : g_chk
      $error("gti_target: timing parameters too small");
   end

   // ************************************************************
   // Input synchronisers and bus events
   // ************************************************************
   logic [1:0]          scl_q;
   logic [1:0]          sda_q;
   logic                scl_p;
   logic                sda_p;
   logic                scl_s;
   logic                sda_s;
   logic                rise;
   logic                fall;
   logic                start;
   logic                stop;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         scl_q <= 2'h3;
         sda_q <= 2'h3;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else if (ce) begin
         scl_q <= {scl_q[0], scl_i};
         sda_q <= {sda_q[0], sda_i};
         scl_p <= scl_q[1];
         sda_p <= sda_q[1];
      end
   end

   assign scl_s = scl_q[1];
   assign sda_s = sda_q[1];
   assign rise  = scl_s & ~scl_p;
   assign fall  = ~scl_s & scl_p;
   assign start = scl_s & scl_p & sda_p & ~sda_s;
   assign stop  = scl_s & scl_p & ~sda_p & sda_s;

   // ************************************************************
   // Bus-low timeout
   // ************************************************************
   logic [TW-1:0]       to_cnt_r;
   logic                to_r;
   logic                sleep_r;
   logic                bus_low;

   assign bus_low = ~scl_s | ~sda_s;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         to_cnt_r <= '0;
         to_r     <= 1'b0;
         sleep_r  <= 1'b0;
      end else if (ce) begin
         if (!bus_low) begin
            to_cnt_r <= '0;
            to_r     <= 1'b0;
            sleep_r  <= 1'b0;
         end else begin
            if (to_cnt_r != TO_SLP) begin
               to_cnt_r <= to_cnt_r + 1'b1;
            end
            if (to_cnt_r == TO_END - 1'b1) begin
               to_r <= 1'b1;
            end
            if (to_cnt_r == TO_SLP - 1'b1) begin
               sleep_r <= 1'b1;
            end
         end
      end
   end

   // ************************************************************
   // Transfer state machine
   // ************************************************************
   gti_pkg::gti_state_t state_r;
   logic [7:0]          sh_r;
   logic [7:0]          tx_r;
   logic [3:0]          bc_r;
   logic                rw_r;
   logic                rack_r;
   logic                hack_r;
   logic                sda_oe_r;
   logic [7:0]          ptr_r;
   logic                we_r;
   logic [7:0]          wdata_r;
   logic                live;
   logic                byte_end;
   logic                acc_cmd;
   logic                acc_wr;
   logic                rd_ack;

   assign live     = ~to_r & ~stop & ~start;
   assign byte_end = live & fall & (bc_r == gti_pkg::BYTE_BITS);
   assign acc_cmd  = byte_end & (state_r == gti_pkg::GTI_CMD) & (sh_r <= gti_pkg::MAX_CMD);
   assign acc_wr   = byte_end & (state_r == gti_pkg::GTI_WDATA) & ~cmd_ro;
   assign rd_ack   = live & rack_r & rise & ~sda_s;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r  <= gti_pkg::GTI_IDLE;
         sh_r     <= 8'h00;
         tx_r     <= 8'h00;
         bc_r     <= 4'h0;
         rw_r     <= 1'b0;
         rack_r   <= 1'b0;
         hack_r   <= 1'b0;
         sda_oe_r <= 1'b0;
      end else if (ce) begin
         if (to_r || stop) begin
            state_r  <= gti_pkg::GTI_IDLE;
            sda_oe_r <= 1'b0;
            rack_r   <= 1'b0;
         end else if (start) begin
            state_r  <= gti_pkg::GTI_ADDR;
            bc_r     <= 4'h0;
            sda_oe_r <= 1'b0;
            rack_r   <= 1'b0;
         end else begin
            case (state_r)
               gti_pkg::GTI_ADDR, gti_pkg::GTI_CMD, gti_pkg::GTI_WDATA: begin
                  if (rise) begin
                     sh_r <= {sh_r[6:0], sda_s};
                     bc_r <= bc_r + 4'h1;
                  end else if (byte_end) begin
                     if (state_r == gti_pkg::GTI_ADDR) begin
                        if (sh_r[7:1] == gti_pkg::TGT_ADDR) begin
                           state_r  <= gti_pkg::GTI_ACKA;
                           rw_r     <= sh_r[0];
                           sda_oe_r <= 1'b1;
                        end else begin
                           state_r <= gti_pkg::GTI_IDLE;
                        end
                     end else if (acc_cmd) begin
                        state_r  <= gti_pkg::GTI_ACKC;
                        sda_oe_r <= 1'b1;
                     end else if (acc_wr) begin
                        state_r  <= gti_pkg::GTI_ACKW;
                        sda_oe_r <= 1'b1;
                     end else begin
                        state_r <= gti_pkg::GTI_IDLE;
                     end
                  end
               end
               gti_pkg::GTI_ACKA, gti_pkg::GTI_ACKC, gti_pkg::GTI_ACKW: begin
                  if (fall) begin
                     bc_r <= 4'h0;
                     if (state_r == gti_pkg::GTI_ACKA && rw_r) begin
                        state_r  <= gti_pkg::GTI_RDATA;
                        tx_r     <= cmd_rdata;
                        sda_oe_r <= ~cmd_rdata[7];
                     end else begin
                        state_r  <= (state_r == gti_pkg::GTI_ACKA) ? gti_pkg::GTI_CMD
                                                                   : gti_pkg::GTI_WDATA;
                        sda_oe_r <= 1'b0;
                     end
                  end
               end
               gti_pkg::GTI_RDATA: begin
                  if (rack_r) begin
                     if (rise) begin
                        hack_r <= ~sda_s;
                     end else if (fall) begin
                        rack_r <= 1'b0;
                        bc_r   <= 4'h0;
                        if (hack_r) begin
                           tx_r     <= cmd_rdata;
                           sda_oe_r <= ~cmd_rdata[7];
                        end else begin
                           state_r <= gti_pkg::GTI_IDLE;
                        end
                     end
                  end else if (rise) begin
                     bc_r <= bc_r + 4'h1;
                  end else if (fall) begin
                     if (bc_r == gti_pkg::BYTE_BITS) begin
                        rack_r   <= 1'b1;
                        sda_oe_r <= 1'b0;
                     end else begin
                        tx_r     <= {tx_r[6:0], 1'b0};
                        sda_oe_r <= ~tx_r[6];
                     end
                  end
               end
               default: begin
                  sda_oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Address pointer and command port
   // ************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ptr_r   <= 8'h00;
         we_r    <= 1'b0;
         wdata_r <= 8'h00;
      end else if (ce) begin
         we_r <= acc_wr;
         if (acc_wr) begin
            wdata_r <= sh_r;
         end
         if (acc_cmd) begin
            ptr_r <= sh_r;
         end else if (we_r || rd_ack) begin
            ptr_r <= ptr_r + 8'h01;
         end
      end
   end

   // ************************************************************
   // Clock stretching
   // ************************************************************
   // The device only ever pulls SCL low after the host has pulled it
   // low, so a stretch never cuts a high phase short.
   logic                wake_r;
   logic [WW-1:0]       wcnt_r;
   logic                scl_oe_r;
   logic                hold;

   // Flow control waits for the address match, so other targets' traffic is held only by the wake stretch.
   assign hold = wake_r | (busy_i & (state_r != gti_pkg::GTI_IDLE)
                                  & (state_r != gti_pkg::GTI_ADDR));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wake_r   <= 1'b0;
         wcnt_r   <= '0;
         scl_oe_r <= 1'b0;
      end else if (ce) begin
         if (to_r || stop) begin
            wake_r <= 1'b0;
         end else if (start && asleep_i) begin
            wake_r <= 1'b1;
            wcnt_r <= WW'(1);
         end else if (wake_r && scl_oe_r) begin
            wcnt_r <= wcnt_r + 1'b1;
            if (wcnt_r == WK_END - 1'b1) begin
               wake_r <= 1'b0;
            end
         end
         scl_oe_r <= ~to_r & (scl_oe_r | fall) & hold;
      end
   end

   assign scl_o   = 1'b0;
   assign sda_o   = 1'b0;
   assign scl_oe  = scl_oe_r;
   assign sda_oe  = sda_oe_r;
   assign sleep_o = sleep_r;
   assign cmd_o   = '{we: we_r, addr: ptr_r, wdata: wdata_r};

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys iff ce);
   endclocking
   default disable iff (rst);

   property p_addr_ack;
      state_r == gti_pkg::GTI_ACKA |-> sh_r[7:1] == gti_pkg::TGT_ADDR && sda_oe_r;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("ack without own address");

   property p_quick;
      (state_r == gti_pkg::GTI_ACKA && rw_r && fall && live) |=> tx_r == $past(cmd_rdata);
   endproperty
   a_quick: assert property (p_quick) else $error("read byte not from pointer");

   property p_rd_inc;
      rd_ack |=> ptr_r == $past(ptr_r) + 8'h01;
   endproperty
   a_rd_inc: assert property (p_rd_inc) else $error("pointer not advanced on host ack");

   property p_wr_inc;
      acc_wr |=> we_r && cmd_o.addr == $past(ptr_r) ##1 ptr_r == $past(ptr_r, 2) + 8'h01;
   endproperty
   a_wr_inc: assert property (p_wr_inc) else $error("write not at consecutive address");

   property p_ro_nack;
      (byte_end && state_r == gti_pkg::GTI_WDATA && cmd_ro) |=> !sda_oe_r && !we_r;
   endproperty
   a_ro_nack: assert property (p_ro_nack) else $error("read-only write acknowledged");

   property p_cmd_nack;
      (byte_end && state_r == gti_pkg::GTI_CMD && sh_r > gti_pkg::MAX_CMD)
         |=> !sda_oe_r && state_r == gti_pkg::GTI_IDLE;
   endproperty
   a_cmd_nack: assert property (p_cmd_nack) else $error("high command acknowledged");

   property p_timeout;
      (bus_low && to_cnt_r == TO_END - 1'b1) |=> ##1 !scl_oe && !sda_oe;
   endproperty
   a_timeout: assert property (p_timeout) else $error("lines not released on timeout");

   property p_sleep;
      $rose(sleep_r) |-> $past(to_r) && bus_low;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep without timeout");

   property p_wake;
      (start && asleep_i && !to_r) |=> wake_r;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake stretch when asleep");

   property p_own_stretch;
      scl_oe |-> $past(wake_r) || ($past(busy_i) && $past(state_r) != gti_pkg::GTI_IDLE
                                  && $past(state_r) != gti_pkg::GTI_ADDR);
   endproperty
   a_own_stretch: assert property (p_own_stretch) else $error("stretch outside packet");

   c_write: cover property (acc_wr ##[1:200] acc_wr);
   c_read:  cover property (rd_ack);
   c_wake:  cover property (wake_r && scl_oe);
   c_sleep: cover property ($rose(sleep_r));
endmodule

// file: tb/gti_host.sv
// Behavioural I2C host controller that drives the gauge target's bus.
`timescale 1ns/1ps
module gti_host (
   output logic      scl_low,
   output logic      sda_low,
   input  wire logic scl,
   input  wire logic sda
);
   // Half period of the link clock; 400 ns gives the 800 ns bench period.
   int half = 400;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // Waits out a stretch, bounded so that a stuck line cannot hang the run.
   task automatic wait_high();
      int n;
      n = 0;
      while (scl !== 1'b1 && n < 100000) begin
         #10;
         n++;
      end
   endtask
   // The odd offset keeps the link edges unrelated to the system clock.
   task automatic start();
      #37;
      #(half / 2) sda_low = 1'b0;
      #(half / 2) scl_low = 1'b0;
      wait_high();
      #(half) sda_low = 1'b1;
      #(half) scl_low = 1'b1;
   endtask
   task automatic bit_io(input logic b, output logic r);
      #(half / 2) sda_low = ~b;
      #(half / 2) scl_low = 1'b0;
      wait_high();
      #(half) r = sda;
      scl_low = 1'b1;
   endtask
   task automatic byte_io(input logic [7:0] d, input logic a9, output logic [7:0] q,
                          output logic r9);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(a9, r9);
   endtask
   task automatic stop();
      #(half / 2) sda_low = 1'b1;
      #(half / 2) scl_low = 1'b0;
      wait_high();
      #(half) sda_low = 1'b0;
      #66000;
   endtask
   task automatic hold(input logic v);
      sda_low = v;
   endtask
endmodule

// file: tb/testbench.sv
// Self-checking testbench of the gauge I2C target engine.
`timescale 1ns/1ps
module testbench;
   // ************************************************************
   // Stimulus, wiring and checking
   // ************************************************************
   // The timeout must outlast the longest low run of a slow link packet.
   localparam int unsigned TO_CYC = 4000;
   localparam int unsigned WK_CYC = 20;
   logic              clk_sys = 1'b0;
   logic              rst = 1'b1;
   logic              ce = 1'b1;
   logic              asleep_i = 1'b0;
   logic              busy_i = 1'b0;
   logic              scl_o;
   logic              scl_oe;
   logic              sda_o;
   logic              sda_oe;
   logic              sleep_o;
   gti_pkg::gti_cmd_t cmd_o;
   logic              scl_low;
   logic              sda_low;
   logic [7:0]        mem [256];
   logic              ro [256];
   logic [15:0]       expq [$];
   int                errors = 0;
   int                samples_checked = 0;
   int                run_len = 0;
   int                max_len = 0;
   // Both lines have pull-ups: a released line reads high.
   wire logic         scl = ~(scl_low | scl_oe);
   wire logic         sda = ~(sda_low | sda_oe);
   wire logic [7:0]   cmd_rdata = mem[cmd_o.addr];
   wire logic         cmd_ro = ro[cmd_o.addr];

   always #50 clk_sys = ~clk_sys;

   gti_target #(
      .TIMEOUT_CYC (TO_CYC),
      .WAKE_CYC    (WK_CYC)
   ) uut (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .ce        (ce),
      .scl_i     (scl),
      .sda_i     (sda),
      .asleep_i  (asleep_i),
      .busy_i    (busy_i),
      .cmd_rdata (cmd_rdata),
      .cmd_ro    (cmd_ro),
      .scl_o     (scl_o),
      .scl_oe    (scl_oe),
      .sda_o     (sda_o),
      .sda_oe    (sda_oe),
      .sleep_o   (sleep_o),
      .cmd_o     (cmd_o)
   );

   gti_host host (
      .scl_low (scl_low),
      .sda_low (sda_low),
      .scl     (scl),
      .sda     (sda)
   );

   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (e !== g) begin
         errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // A write strobe with no pending note is always a mismatch.
   always @(negedge clk_sys) begin
      if (scl_oe === 1'b1) begin
         run_len <= run_len + 1;
         if (run_len + 1 > max_len) begin
            max_len <= run_len + 1;
         end
      end else begin
         run_len <= 0;
      end
      if (cmd_o.we === 1'b1) begin
         chk(expq.size() > 0 ? expq.pop_front() : 16'hXXXX, {cmd_o.addr, cmd_o.wdata});
      end
   end

   task automatic send(input logic [7:0] b, input logic nack);
      logic [7:0] q;
      logic       r;
      host.byte_io(b, 1'b1, q, r);
      chk({15'h0000, nack}, {15'h0000, r});
   endtask

   task automatic recv(input logic last, input logic [7:0] e);
      logic [7:0] q;
      logic       r;
      host.byte_io(8'hFF, last, q, r);
      chk({8'h00, e}, {8'h00, q});
   endtask

   task automatic wpkt(input logic [7:0] a, input int n);
      logic [7:0] d;
      host.start();
      send(8'hAA, 1'b0);
      send(a, 1'b0);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         expq.push_back({a + 8'(i), d});
         send(d, 1'b0);
      end
      host.stop();
   endtask

   initial begin
      #6_000_000;
      errors++;
      end_of_test();
   end

   initial begin
      logic [7:0] q;
      logic       r;
      void'($urandom(51403));
      foreach (mem[i]) begin
         mem[i] = 8'($urandom);
         ro[i] = 1'b0;
      end
      ro[8'h20] = 1'b1;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      repeat (3) @(negedge clk_sys);
      wpkt(8'h0A, 1);
      $display("test single write done");
      // Incremental writes are only legal on a slow link.
      host.half = 5000;
      wpkt(8'h00, 2);
      host.half = 400;
      // Result waits and command spacing, scaled like the bus timeout.
      #400_000;
      $display("test incremental write done");
      host.start();
      send(8'hAA, 1'b0);
      send(8'h30, 1'b0);
      host.start();
      send(8'hAB, 1'b0);
      recv(1'b0, mem[8'h30]);
      recv(1'b1, mem[8'h31]);
      host.stop();
      host.start();
      send(8'hAB, 1'b0);
      recv(1'b1, mem[8'h31]);
      host.stop();
      $display("test reads done");
      host.start();
      send(8'hA8, 1'b1);
      host.stop();
      for (int c = 0; c < 2; c++) begin
         host.start();
         send(8'hAA, 1'b0);
         send(8'h6B + 8'(c), 1'(c));
         host.stop();
      end
      host.start();
      send(8'hAA, 1'b0);
      send(8'h20, 1'b0);
      send(8'h5A, 1'b1);
      host.stop();
      $display("test refusals done");
      @(negedge clk_sys) asleep_i = 1'b1;
      max_len = 0;
      host.start();
      send(8'hA8, 1'b1);
      host.stop();
      chk(16'h0001, {15'h0000, max_len > 0 && max_len <= WK_CYC});
      @(negedge clk_sys) asleep_i = 1'b0;
      busy_i = 1'b1;
      max_len = 0;
      host.start();
      send(8'hA8, 1'b1);
      host.stop();
      chk(16'h0000, {15'h0000, max_len > 0});
      fork
         wpkt(8'h10, 1);
         begin
            #12000;
            @(negedge clk_sys) busy_i = 1'b0;
         end
      join
      chk(16'h0001, {15'h0000, max_len > 0});
      $display("test stretch done");
      @(negedge clk_sys) busy_i = 1'b1;
      host.start();
      max_len = 0;
      host.byte_io(8'hAA, 1'b1, q, r);
      host.byte_io(8'h0A, 1'b1, q, r);
      host.stop();
      @(negedge clk_sys) busy_i = 1'b0;
      chk(16'h0001, {15'h0000, max_len > 0 && max_len <= TO_CYC});
      host.hold(1'b1);
      repeat (TO_CYC + 15) @(negedge clk_sys);
      chk(16'h0004, {13'h0000, sleep_o, scl_oe, sda_oe});
      host.hold(1'b0);
      repeat (10) @(negedge clk_sys);
      chk(16'h0000, {15'h0000, sleep_o});
      chk(16'h0000, 16'(expq.size()));
      $display("test timeout done");
      end_of_test();
   end
endmodule
